// ### logic/fcct_pkg.sv
`default_nettype none
package fcct_pkg;
	// control word fields
	localparam int CTL_IS_CONTROL = 0;
	localparam int CTL_SOFT_STOP = 1;
	localparam int CTL_TC_FOLLOWS = 2;
	localparam int CTL_EXT_TRIGGER = 3;
	localparam int CTL_EDGE_RISING = 4;
	localparam int CTL_PRESCALE_256 = 5;
	localparam int CTL_COUNTER_MODE = 6;
	localparam int CTL_INT_ENABLE = 7;
	localparam logic [7:0] CTL_RESET = 8'h00;
	// vector layout: bits 7..3 from host, 2..1 channel, 0 zero
	localparam int VEC_CH_LSB = 1;
	localparam logic [4:0] VEC_RESET = 5'h00;
	localparam int NUM_CH = 4;
	localparam int NUM_ZC = 3;
	localparam logic [7:0] PRESCALE_SHORT_M1 = 8'h0F;
	localparam logic [7:0] PRESCALE_LONG_M1 = 8'hFF;
	localparam logic [8:0] COUNT_FULL = 9'h100;

	typedef struct packed {
		logic io_request_n;
		logic chip_select_n;
		logic read_n;
		logic opcode_cycle_n;
		logic [1:0] channel_pick;
	} fcct_bus_t;

	typedef enum logic [1:0] {
		FCCT_IDLE = 2'b00,
		FCCT_ARMED = 2'b01,
		FCCT_RUN = 2'b10
	} fcct_state_t;
endpackage : fcct_pkg
`default_nettype wire

// ### logic/fcct_channel.sv
`timescale 1ns/1ps
`default_nettype none
module fcct_channel
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ctl_we,
	input wire logic tc_we,
	input wire logic [7:0] wdata,
	input wire logic ext_edge_in,
	output logic [7:0] count_q,
	output logic zero_q,
	output logic int_en
);
	fcct_pkg::fcct_state_t state_q;
	logic [7:0] ctl_q;
	logic [7:0] tc_q;
	logic [7:0] pre_q;
	logic [8:0] cnt_q;
	logic ext_q;
	logic edge_seen;
	logic slope_flip;
	logic tick;

	function automatic logic [8:0] reload(input logic [7:0] v);
		reload = (v == 8'h00) ? fcct_pkg::COUNT_FULL : {1'b0, v};
	endfunction : reload

	assign int_en = ctl_q[fcct_pkg::CTL_INT_ENABLE];
	assign count_q = cnt_q[7:0];
	assign slope_flip = ctl_we && state_q != fcct_pkg::FCCT_IDLE
		&& wdata[fcct_pkg::CTL_EDGE_RISING]
		!= ctl_q[fcct_pkg::CTL_EDGE_RISING];
	assign edge_seen = (ctl_q[fcct_pkg::CTL_EDGE_RISING] ?
		(ext_edge_in && !ext_q) : (!ext_edge_in && ext_q)) || slope_flip;
	// one decrement per prescaler wrap in timer mode, per edge otherwise
	assign tick = state_q == fcct_pkg::FCCT_RUN &&
		(ctl_q[fcct_pkg::CTL_COUNTER_MODE] ? edge_seen :
		pre_q == 8'h00);

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			ext_q <= 1'b0;
		else
			ext_q <= ext_edge_in;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			ctl_q <= fcct_pkg::CTL_RESET;
		else if (ctl_we)
			ctl_q <= wdata;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			tc_q <= 8'h00;
		else if (tc_we)
			tc_q <= wdata;
	end

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk)
	begin
		if (sys_rst || state_q != fcct_pkg::FCCT_RUN || pre_q == 8'h00)
			pre_q <= ctl_q[fcct_pkg::CTL_PRESCALE_256] ?
				fcct_pkg::PRESCALE_LONG_M1 :
				fcct_pkg::PRESCALE_SHORT_M1;
		else
			pre_q <= pre_q - 8'h01;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state_q <= fcct_pkg::FCCT_IDLE;
			cnt_q <= 9'h000;
			zero_q <= 1'b0;
		end
		else
		begin
			zero_q <= 1'b0;
			if (ctl_we && wdata[fcct_pkg::CTL_SOFT_STOP])
				state_q <= fcct_pkg::FCCT_IDLE;
			else
			begin
				case (state_q)
					fcct_pkg::FCCT_IDLE:
					begin
						if (tc_we)
						begin
							cnt_q <= reload(wdata);
							// counter mode runs at once; timer waits per trigger
							state_q <= ctl_q[fcct_pkg::CTL_COUNTER_MODE] ?
								fcct_pkg::FCCT_RUN :
								fcct_pkg::FCCT_ARMED;
						end
					end
					fcct_pkg::FCCT_ARMED:
					begin
						// auto trigger starts next cycle; external waits edge
						if (!ctl_q[fcct_pkg::CTL_EXT_TRIGGER] || edge_seen)
							state_q <= fcct_pkg::FCCT_RUN;
					end
					fcct_pkg::FCCT_RUN:
					begin
						if (tick)
						begin
							if (cnt_q == 9'h001)
							begin
								// a constant written while armed or running takes effect here; in idle it loads at once
								cnt_q <= reload(tc_q);
								zero_q <= 1'b1;
							end
							else
								cnt_q <= cnt_q - 9'h001;
						end
					end
					default:
						state_q <= fcct_pkg::FCCT_IDLE;
				endcase
			end
		end
	end
endmodule : fcct_channel
`default_nettype wire

// ### logic/fcct_top.sv
`timescale 1ns/1ps
`default_nettype none
module fcct_top
#(
	parameter int NUM_CH = fcct_pkg::NUM_CH
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire fcct_pkg::fcct_bus_t bus,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe_n,
	input wire logic [NUM_CH-1:0] ext_edge_in,
	output logic [fcct_pkg::NUM_ZC-1:0] zero_count_pulse,
	output logic int_req_n,
	input wire logic chain_enable_in,
	output logic chain_enable_out
);
	logic io_sel;
	logic wr_now;
	logic rd_now;
	logic ack_now;
	logic wr_q;
	logic [NUM_CH-1:0] tc_expect_q;
	logic [NUM_CH-1:0] ctl_we;
	logic [NUM_CH-1:0] tc_we;
	logic [7:0] cnt [NUM_CH];
	logic [NUM_CH-1:0] zero;
	logic [NUM_CH-1:0] ien;
	logic [NUM_CH-1:0] pend_q;
	logic [NUM_CH-1:0] serv_q;
	logic [4:0] vec_q;
	logic [1:0] pick;
	logic [1:0] win;
	logic any_pend;

	function automatic logic [1:0] first_set(input logic [NUM_CH-1:0] v);
		first_set = 2'b00;
		for (int i = NUM_CH - 1; i >= 0; i--)
			if (v[i])
				first_set = 2'(i);
	endfunction : first_set

	assign pick = bus.channel_pick;
	assign io_sel = !bus.io_request_n && !bus.chip_select_n
		&& bus.opcode_cycle_n;
	assign rd_now = io_sel && !bus.read_n;
	assign wr_now = io_sel && bus.read_n && !wr_q;
	assign ack_now = !bus.io_request_n && !bus.opcode_cycle_n;
	assign any_pend = |(pend_q & ien);
	assign win = first_set(pend_q & ien);

	////////////////////////////////////////////////////////////////////
	// a write cycle is one strobe held over several clocks: act once
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			wr_q <= 1'b0;
		else
			wr_q <= io_sel && bus.read_n;
	end

	always_comb
	begin
		ctl_we = '0;
		tc_we = '0;
		if (wr_now)
		begin
			if (tc_expect_q[pick])
				tc_we[pick] = 1'b1;
			else if (data_in[fcct_pkg::CTL_IS_CONTROL])
				ctl_we[pick] = 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			tc_expect_q <= '0;
		else
			for (int i = 0; i < NUM_CH; i++)
				if (tc_we[i])
					tc_expect_q[i] <= 1'b0;
				else if (ctl_we[i])
					tc_expect_q[i] <= data_in[fcct_pkg::CTL_TC_FOLLOWS];
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			vec_q <= fcct_pkg::VEC_RESET;
		else if (wr_now && !tc_expect_q[pick] && pick == 2'b00
			&& !data_in[fcct_pkg::CTL_IS_CONTROL])
			vec_q <= data_in[7:3];
	end

	////////////////////////////////////////////////////////////////////
	for (genvar g = 0; g < NUM_CH; g++)
	begin : g_ch
		fcct_channel u_ch
		(
			.clk(clk),
			.sys_rst(sys_rst),
			.ctl_we(ctl_we[g]),
			.tc_we(tc_we[g]),
			.wdata(data_in),
			.ext_edge_in(ext_edge_in[g]),
			.count_q(cnt[g]),
			.zero_q(zero[g]),
			.int_en(ien[g])
		);
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			zero_count_pulse <= '0;
		else
			zero_count_pulse <= zero[fcct_pkg::NUM_ZC-1:0];
	end

	////////////////////////////////////////////////////////////////////
	// pending is set on zero and cleared by the acknowledge; set wins
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			pend_q <= '0;
			serv_q <= '0;
		end
		else
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				if (zero[i] && ien[i])
					pend_q[i] <= 1'b1;
				else if (!ien[i] || (ack_now && chain_enable_in
					&& any_pend && win == 2'(i)))
					pend_q[i] <= 1'b0;
				// service ends on the next opcode fetch (opcode cycle with read_n low) seen after ack
				if (ack_now && chain_enable_in && any_pend
					&& win == 2'(i))
					serv_q[i] <= 1'b1;
				else if (!bus.opcode_cycle_n && !bus.read_n)
					serv_q[i] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			int_req_n <= 1'b1;
			// the chain must stay open for others while we are held
			chain_enable_out <= chain_enable_in;
		end
		else
		begin
			int_req_n <= !(any_pend && chain_enable_in);
			chain_enable_out <= chain_enable_in && !(|serv_q);
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			data_out <= 8'h00;
			data_oe_n <= 1'b1;
		end
		else if (ack_now && chain_enable_in && any_pend)
		begin
			data_out <= {vec_q, win, 1'b0};
			data_oe_n <= 1'b0;
		end
		else if (rd_now)
		begin
			data_out <= cnt[pick];
			data_oe_n <= 1'b0;
		end
		else
		begin
			data_out <= 8'h00;
			data_oe_n <= 1'b1;
		end
	end
endmodule : fcct_top
`default_nettype wire

// ### sim/fcct_props.sv
`timescale 1ns/1ps
`default_nettype none
module fcct_props
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire fcct_pkg::fcct_bus_t bus,
	input wire logic [7:0] data_out,
	input wire logic data_oe_n,
	input wire logic [fcct_pkg::NUM_ZC-1:0] zero_count_pulse,
	input wire logic int_req_n,
	input wire logic chain_enable_in,
	input wire logic chain_enable_out
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic io_s;
	logic rd_s;
	logic ack_s;
	assign io_s = !bus.io_request_n && !bus.chip_select_n;
	assign rd_s = io_s && !bus.read_n && bus.opcode_cycle_n;
	assign ack_s = !bus.io_request_n && !bus.opcode_cycle_n;
	////////////////////////////////////////////////////////////////////
	// reset is the antecedent here, so it must not disable itself
	property p_rst;
		disable iff (1'b0)
		sys_rst |=> data_oe_n && int_req_n && zero_count_pulse == 3'h0;
	endproperty
	property p_rchn;
		disable iff (1'b0)
		sys_rst |=> chain_enable_out == $past(chain_enable_in);
	endproperty
	property p_chn;
		!chain_enable_in |=> !chain_enable_out;
	endproperty
	property p_irq;
		!chain_enable_in |=> int_req_n;
	endproperty
	property p_zc;
		$rose(zero_count_pulse[0]) |=> !zero_count_pulse[0];
	endproperty
	property p_rd;
		rd_s |=> !data_oe_n;
	endproperty
	property p_wr;
		io_s && bus.read_n && bus.opcode_cycle_n |=> data_oe_n;
	endproperty
	property p_vec;
		ack_s ##1 !data_oe_n |-> data_out[0] == 1'b0;
	endproperty
	property p_svc;
		ack_s ##1 !data_oe_n |=> !chain_enable_out;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	a_rchn: assert property (p_rchn) else $error("chain in reset");
	a_chn: assert property (p_chn) else $error("chain out");
	a_irq: assert property (p_irq) else $error("irq blocked");
	a_zc: assert property (p_zc) else $error("zero pulse");
	a_rd: assert property (p_rd) else $error("read drive");
	a_wr: assert property (p_wr) else $error("write drove");
	a_vec: assert property (p_vec) else $error("vector bit0");
	a_svc: assert property (p_svc) else $error("in service");
	c_rd: cover property (rd_s ##1 !data_oe_n);
	c_ack: cover property (ack_s ##1 !data_oe_n);
	c_zc: cover property (zero_count_pulse[1]);
endmodule : fcct_props
bind fcct_top fcct_props fcct_props_inst
(
	.clk(clk), .sys_rst(sys_rst), .bus(bus), .data_out(data_out),
	.data_oe_n(data_oe_n), .zero_count_pulse(zero_count_pulse),
	.int_req_n(int_req_n), .chain_enable_in(chain_enable_in),
	.chain_enable_out(chain_enable_out)
);
`default_nettype wire

// ### sim/fcct_host.sv
`timescale 1ns/1ps
`default_nettype none
module fcct_host
(
	input wire logic clk,
	output var fcct_pkg::fcct_bus_t bus,
	output logic [7:0] data_in,
	input wire logic [7:0] data_out,
	input wire logic data_oe_n
);
	initial
	begin
		bus = 6'h3C;
		data_in = 8'h00;
	end
	// one bus cycle then an idle one; read_n high means write
	task automatic cyc(input logic [5:0] b, input logic [7:0] d,
		output logic [8:0] r);
		@(negedge clk);
		bus = b;
		data_in = d;
		@(negedge clk);
		r = {data_oe_n, data_out};
		bus = 6'h3C;
		// a released bus must not keep showing the old byte
		data_in = ~d;
		@(negedge clk);
	endtask : cyc
endmodule : fcct_host
`default_nettype wire

// ### sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk;
	logic sys_rst;
	logic [3:0] ext_edge_in;
	logic chain_enable_in;
	fcct_pkg::fcct_bus_t bus;
	logic [7:0] data_in;
	logic [7:0] data_out;
	logic data_oe_n;
	logic [2:0] zc;
	logic int_req_n;
	logic chain_enable_out;
	logic [8:0] r;
	int num_errors = 0;
	int n_checks = 0;
	int zc_cnt [3] = '{0, 0, 0};
	fcct_top fcct_top_inst
	(
		.clk(clk), .sys_rst(sys_rst), .bus(bus), .data_in(data_in),
		.data_out(data_out), .data_oe_n(data_oe_n),
		.ext_edge_in(ext_edge_in), .zero_count_pulse(zc),
		.int_req_n(int_req_n), .chain_enable_in(chain_enable_in),
		.chain_enable_out(chain_enable_out)
	);
	fcct_host fcct_host_inst
	(
		.clk(clk), .bus(bus), .data_in(data_in), .data_out(data_out),
		.data_oe_n(data_oe_n)
	);
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		for (int i = 0; i < 3; i++)
			if (zc[i] === 1'b1)
				zc_cnt[i]++;
	end
	////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic test_done;
		$display("checks=%0d errors=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done
	task automatic wr(input logic [1:0] ch, input logic [7:0] d);
		fcct_host_inst.cyc({4'b0011, ch}, d, r);
	endtask : wr
	// counter is sampled on the falling edge, clear of its update
	task automatic wait_zc(input int ch, input int lim, output int n);
		int c0;
		c0 = zc_cnt[ch];
		n = 0;
		while (zc_cnt[ch] == c0 && n < lim)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= lim)
		begin
			num_errors++;
			test_done();
		end
	endtask : wait_zc
	////////////////////////////////////////////////////////////////////
	task automatic t_timer(input logic [7:0] ctl, input logic [7:0] tc,
		input int per);
		int n;
		wr(2'd0, ctl);
		wr(2'd0, tc);
		wait_zc(0, per + 40, n);
		wait_zc(0, per + 8, n);
		check(16'(n), 16'(per));
	endtask : t_timer
	task automatic edges(input int ch, input int k);
		for (int j = 0; j < k; j++)
		begin
			@(negedge clk);
			ext_edge_in[ch] = 1'b1;
			repeat (3) @(negedge clk);
			ext_edge_in[ch] = 1'b0;
		end
		repeat (4) @(negedge clk);
	endtask : edges
	task automatic t_count;
		wr(2'd0, 8'h40);
		wr(2'd1, 8'hD7);
		wr(2'd1, 8'h03);
		edges(1, 3);
		check(16'(zc_cnt[1]), 16'h0001);
		check(16'(int_req_n), 16'h0000);
		fcct_host_inst.cyc(6'b011000, 8'h00, r);
		check(16'(r), 16'h0042);
		check(16'(chain_enable_out), 16'h0000);
		// opcode fetch ends the service period
		fcct_host_inst.cyc(6'b110000, 8'h00, r);
		repeat (2) @(negedge clk);
		check(16'(chain_enable_out), 16'h0001);
	endtask : t_count
	// chain held low blocks the request and the acknowledge
	task automatic t_chain;
		chain_enable_in = 1'b0;
		edges(1, 3);
		check(16'(zc_cnt[1]), 16'h0002);
		check(16'(int_req_n), 16'h0001);
		check(16'(chain_enable_out), 16'h0000);
		fcct_host_inst.cyc(6'b011000, 8'h00, r);
		check(16'(r), 16'h0100);
		chain_enable_in = 1'b1;
		repeat (2) @(negedge clk);
		check(16'(int_req_n), 16'h0000);
		// same slope and mode, only the interrupt enable drops
		wr(2'd1, 8'h51);
		repeat (2) @(negedge clk);
		check(16'(int_req_n), 16'h0001);
	endtask : t_chain
	task automatic t_reset;
		chain_enable_in = 1'b0;
		sys_rst = 1'b1;
		@(negedge clk);
		check(16'(chain_enable_out), 16'h0000);
		chain_enable_in = 1'b1;
		@(negedge clk);
		check(16'({data_oe_n, int_req_n, zc, chain_enable_out}),
			16'h0031);
		sys_rst = 1'b0;
		fcct_host_inst.cyc({4'b0001, 2'd2}, 8'h00, r);
		check(16'(r), 16'h0000);
	endtask : t_reset
	task automatic t_read;
		for (int i = 2; i < 4; i++)
		begin
			wr(2'(i), 8'h57);
			wr(2'(i), 8'h10 + 8'(i));
			fcct_host_inst.cyc({4'b0001, 2'(i)}, 8'h00, r);
			check(16'(r), 16'h0010 + 16'(i));
			wr(2'(i), 8'h41);
			fcct_host_inst.cyc({4'b0001, 2'(i)}, 8'h00, r);
			check(16'(r), 16'h000F + 16'(i));
			// new constant waits for zero; vector byte off channel 0 ignored
			wr(2'(i), 8'h45);
			wr(2'(i), 8'h05);
			wr(2'(i), 8'h90);
			fcct_host_inst.cyc({4'b0001, 2'(i)}, 8'h00, r);
			check(16'(r), 16'h000F + 16'(i));
		end
	endtask : t_read
	initial
	begin
		sys_rst = 1'b1;
		ext_edge_in = 4'h0;
		chain_enable_in = 1'b1;
		repeat (12) @(negedge clk);
		sys_rst = 1'b0;
		@(negedge clk);
		check(16'({data_oe_n, int_req_n, zc, chain_enable_out}),
			16'h0031);
		t_timer(8'h07, 8'h02, 32);
		t_timer(8'h27, 8'h01, 256);
		t_timer(8'h07, 8'h00, 4096);
		t_count();
		t_chain();
		t_read();
		t_reset();
		test_done();
	end
endmodule : testbench
`default_nettype wire
